// ===== design/lpdcd_pkg.sv
// Package: opcodes, reset values and carrier types of the drive command decoder
// Functional notes
// - Bias opcode plus byte, low two bits
// - Bias resets 00; host never writes 03H
// - Volume opcode plus byte, low seven bits
// - Volume zero smallest, monotonic, resets zero
// - Discharge command bit 0, off at reset
// - Discharge active while reset held low
// - Power save bit 0; settings retained
// - Power save stops oscillator, supply, outputs
// - Power save off restores prior state
// - Display blank output low in power save
// - Temperature slope byte, three bits, resets 000
// - Status read returns slope on bits 2..0
// - Sensor command bit 0, off at reset
// - Drive method bits 4,3; reset 0,1
// - Bit 4 zero overlaps frame inversion
// - Bit 3 selects consecutive four selections
// - No-operation changes nothing; here it cancels a pending parameter and clears status mode
package lpdcd_pkg;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_BIAS      = 8'hA2;
    localparam logic [7:0] OP_VOLUME    = 8'h81;
    localparam logic [7:0] OP_DISCHARGE = 8'hEA;
    localparam logic [7:0] OP_PWR_SAVE  = 8'hA8;
    localparam logic [7:0] OP_TEMP      = 8'h4E;
    localparam logic [7:0] OP_STATUS    = 8'h8E;
    localparam logic [7:0] OP_SENSOR    = 8'h28;
    localparam logic [7:0] OP_DRIVE     = 8'hE7;
    localparam logic [7:0] OP_NOP       = 8'hE3;
    localparam logic [7:0] OP_ONEBIT_M  = 8'hFE;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIAS_MSB   = 1;
    localparam int VOL_MSB    = 6;
    localparam int TEMP_MSB   = 2;
    localparam int OVL_BIT    = 4;
    localparam int CONS_BIT   = 3;
    localparam int ONOFF_BIT  = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] BIAS_RST   = 2'h0;
    localparam logic [1:0] BIAS_BAD   = 2'h3;
    localparam logic [6:0] VOL_RST    = 7'h00;
    localparam logic [2:0] TEMP_RST   = 3'h0;
    localparam logic       OVL_RST    = 1'b0;
    localparam logic       CONS_RST   = 1'b1;

    typedef enum logic [2:0] {
        LPD_PARAM_NONE,
        LPD_PARAM_BIAS,
        LPD_PARAM_VOLUME,
        LPD_PARAM_TEMP,
        LPD_PARAM_DRIVE
    } lpd_param_t;

    // Settings carried to the power and drive stages
    typedef struct packed {
        logic [1:0] bias_sel;
        logic [6:0] volume;
        logic [2:0] temp_slope_sel;
        logic       sensor_en;
        logic       inversion_overlap_off;
        logic       consecutive_select_drive;
    } lpd_settings_t;

endpackage : lpdcd_pkg

// ===== design/lpdcd_stage_ctrl.sv
// Module: output stage control derived from the stored settings
`timescale 1ns/1ps
module lpdcd_stage_ctrl (
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    // Decoded state
    input  wire logic                     pwr_save_i,
    input  wire logic                     discharge_i,
    input  wire logic                     nline_inv_on_i,
    input  wire lpdcd_pkg::lpd_settings_t set_i,
    // Stage controls
    output logic                          osc_run_o,
    output logic                          supply_run_o,
    output logic                          drivers_gnd_o,
    output logic                          display_blank_out_o,
    output logic                          discharge_o,
    output logic                          frame_overlap_o,
    output logic                          consecutive_select_drive_o
);

    // Registered controls; the async reset forces discharge on at once
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_run_o           <= 1'b0;
            supply_run_o        <= 1'b0;
            drivers_gnd_o       <= 1'b1;
            display_blank_out_o <= 1'b0;
            discharge_o         <= 1'b1;
        end else begin
            osc_run_o           <= !pwr_save_i;
            supply_run_o        <= !pwr_save_i;
            drivers_gnd_o       <= pwr_save_i;
            display_blank_out_o <= !pwr_save_i;
            discharge_o         <= discharge_i;
        end
    end

    // Overlap only matters while n-line inversion runs
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_overlap_o            <= 1'b0;
            consecutive_select_drive_o <= lpdcd_pkg::CONS_RST;
        end else begin
            frame_overlap_o <= nline_inv_on_i &&
                               !set_i.inversion_overlap_off;
            consecutive_select_drive_o <= set_i.consecutive_select_drive;
        end
    end

endmodule : lpdcd_stage_ctrl

// ===== design/lpdcd_decoder.sv
// Module: host command decoder for drive and power settings
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module lpdcd_decoder (
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    // Host port
    input  wire logic                     cmd_data_select_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    input  wire logic [7:0]               wdata_i,
    output logic      [7:0]               rdata_o,
    // From other command decoders
    input  wire logic                     nline_inv_on_i,
    // Settings and stage controls
    output lpdcd_pkg::lpd_settings_t      settings_o,
    output logic                          pwr_save_o,
    output logic                          osc_run_o,
    output logic                          supply_run_o,
    output logic                          drivers_gnd_o,
    output logic                          display_blank_out_o,
    output logic                          discharge_o,
    output logic                          frame_overlap_o,
    output logic                          consecutive_select_drive_o
);

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    lpdcd_pkg::lpd_param_t pend;
    lpdcd_pkg::lpd_param_t next_pend;
    lpdcd_pkg::lpd_settings_t set_q;
    logic                  discharge;
    logic                  status_mode;
    logic                  cmd_wr;
    logic                  par_wr;

    assign cmd_wr = wr_i && !cmd_data_select_i;
    assign par_wr = wr_i && cmd_data_select_i;

    always_comb begin
        next_pend = pend;
        if (cmd_wr) begin
            unique case (wdata_i)
                lpdcd_pkg::OP_BIAS:   next_pend = lpdcd_pkg::LPD_PARAM_BIAS;
                lpdcd_pkg::OP_VOLUME: next_pend = lpdcd_pkg::LPD_PARAM_VOLUME;
                lpdcd_pkg::OP_TEMP:   next_pend = lpdcd_pkg::LPD_PARAM_TEMP;
                lpdcd_pkg::OP_DRIVE:  next_pend = lpdcd_pkg::LPD_PARAM_DRIVE;
                default:              next_pend = lpdcd_pkg::LPD_PARAM_NONE;
            endcase
        end else if (par_wr) begin
            next_pend = lpdcd_pkg::LPD_PARAM_NONE;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend <= lpdcd_pkg::LPD_PARAM_NONE;
        end else begin
            pend <= next_pend;
        end
    end

    // ------------------------------------------------------------------
    // Parameter settings
    // ------------------------------------------------------------------
    // Forbidden bias code is dropped so the stage never sees it
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            set_q.bias_sel <= lpdcd_pkg::BIAS_RST;
        end else if (par_wr && pend == lpdcd_pkg::LPD_PARAM_BIAS &&
                     wdata_i[lpdcd_pkg::BIAS_MSB:0] != lpdcd_pkg::BIAS_BAD)
        begin
            set_q.bias_sel <= wdata_i[lpdcd_pkg::BIAS_MSB:0];
        end
    end

    // Higher code means higher voltage; code passed unchanged
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            set_q.volume <= lpdcd_pkg::VOL_RST;
        end else if (par_wr && pend == lpdcd_pkg::LPD_PARAM_VOLUME) begin
            set_q.volume <= wdata_i[lpdcd_pkg::VOL_MSB:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            set_q.temp_slope_sel <= lpdcd_pkg::TEMP_RST;
        end else if (par_wr && pend == lpdcd_pkg::LPD_PARAM_TEMP) begin
            set_q.temp_slope_sel <=
                wdata_i[lpdcd_pkg::TEMP_MSB:0];
        end
    end

    // Low three bits must be 011; only bits 4 and 3 are stored
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            set_q.inversion_overlap_off    <= lpdcd_pkg::OVL_RST;
            set_q.consecutive_select_drive <= lpdcd_pkg::CONS_RST;
        end else if (par_wr && pend == lpdcd_pkg::LPD_PARAM_DRIVE) begin
            set_q.inversion_overlap_off <= wdata_i[lpdcd_pkg::OVL_BIT];
            set_q.consecutive_select_drive <= wdata_i[lpdcd_pkg::CONS_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Single-byte commands
    // ------------------------------------------------------------------
    // NOP falls through the three matches below; it still clears pend and status_mode
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            discharge       <= 1'b0;
            pwr_save_o      <= 1'b0;
            set_q.sensor_en <= 1'b0;
        end else if (cmd_wr) begin
            if ((wdata_i & lpdcd_pkg::OP_ONEBIT_M) ==
                lpdcd_pkg::OP_DISCHARGE) begin
                discharge <= wdata_i[lpdcd_pkg::ONOFF_BIT];
            end
            if ((wdata_i & lpdcd_pkg::OP_ONEBIT_M) ==
                lpdcd_pkg::OP_PWR_SAVE) begin
                pwr_save_o <= wdata_i[lpdcd_pkg::ONOFF_BIT];
            end
            if ((wdata_i & lpdcd_pkg::OP_ONEBIT_M) ==
                lpdcd_pkg::OP_SENSOR) begin
                set_q.sensor_en <= wdata_i[lpdcd_pkg::ONOFF_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status read
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_mode <= 1'b0;
        end else if (cmd_wr) begin
            status_mode <= (wdata_i == lpdcd_pkg::OP_STATUS);
        end
    end

    // Upper bits are undefined to the host; driven zero here
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i && cmd_data_select_i && status_mode) begin
            rdata_o <= {5'h00, set_q.temp_slope_sel};
        end else if (rd_i) begin
            rdata_o <= 8'h00;
        end
    end

    // Settings are never touched by power save, so exit restores them
    assign settings_o = set_q;

    // ------------------------------------------------------------------
    // Stage control
    // ------------------------------------------------------------------
    lpdcd_stage_ctrl u_stage (
        .core_clk_i                 (core_clk_i),
        .rst_n_i                    (rst_n_i),
        .pwr_save_i                 (pwr_save_o),
        .discharge_i                (discharge),
        .nline_inv_on_i             (nline_inv_on_i),
        .set_i                      (set_q),
        .osc_run_o                  (osc_run_o),
        .supply_run_o               (supply_run_o),
        .drivers_gnd_o              (drivers_gnd_o),
        .display_blank_out_o        (display_blank_out_o),
        .discharge_o                (discharge_o),
        .frame_overlap_o            (frame_overlap_o),
        .consecutive_select_drive_o (consecutive_select_drive_o)
    );

endmodule : lpdcd_decoder

// ===== sim/lpdcd_host_model.sv
// Host model: parallel command/data port master
`timescale 1ns/1ps
module lpdcd_host_model (
    // Clock
    input  wire logic       core_clk_i,
    // Read return
    input  wire logic [7:0] rdata_i,
    // Host port
    output logic            cmd_data_select_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      wdata_o
);
    // No external supply or clock here, nothing to release
    initial begin
        cmd_data_select_o = 1'b0;
        wr_o              = 1'b0;
        rd_o              = 1'b0;
        wdata_o           = 8'h00;
    end

    // Opcode or parameter byte, back to back allowed
    task automatic put(input logic sel, input logic [7:0] d);
        @(posedge core_clk_i);
        cmd_data_select_o <= sel;
        wr_o              <= 1'b1;
        rd_o              <= 1'b0;
        wdata_o           <= d;
    endtask : put

    // Released data lines toggle so stale bytes never look valid
    task automatic idle();
        @(posedge core_clk_i);
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
        wdata_o <= ~wdata_o;
    endtask : idle

    task automatic get(output logic [7:0] d);
        @(posedge core_clk_i);
        cmd_data_select_o <= 1'b1;
        wr_o              <= 1'b0;
        rd_o              <= 1'b1;
        @(posedge core_clk_i);
        rd_o    <= 1'b0;
        wdata_o <= ~wdata_o;
        #1 d = rdata_i;
    endtask : get
endmodule : lpdcd_host_model

// ===== sim/lpdcd_asserts.sv
// Checker: port timing relations of the drive command decoder
`timescale 1ns/1ps
module lpdcd_asserts (
    // Clock, reset and host port
    input wire logic                     core_clk_i,
    input wire logic                     rst_n_i,
    input wire logic                     cmd_data_select_i,
    input wire logic                     wr_i,
    input wire logic [7:0]               wdata_i,
    input wire logic                     nline_inv_on_i,
    // Settings and stage controls
    input wire lpdcd_pkg::lpd_settings_t settings_o,
    input wire logic                     pwr_save_o,
    input wire logic                     osc_run_o,
    input wire logic                     drivers_gnd_o,
    input wire logic                     display_blank_out_o,
    input wire logic                     discharge_o,
    input wire logic                     frame_overlap_o,
    input wire logic                     consecutive_select_drive_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire opw = wr_i && !cmd_data_select_i;

    property p_vol; opw && wdata_i == lpdcd_pkg::OP_VOLUME ##1 wr_i &&
        cmd_data_select_i |=> settings_o.volume == $past(wdata_i[6:0]);
    endproperty
    a_vol: assert property (p_vol)
        else $error("volume load wrong");
    property p_bias_bad; wr_i && cmd_data_select_i && wdata_i[1:0] == 2'h3
        |=> $stable(settings_o.bias_sel); endproperty
    a_bias_bad: assert property (p_bias_bad)
        else $error("bias 3 stored");
    property p_nop; opw && wdata_i == lpdcd_pkg::OP_NOP
        |=> $stable(settings_o) && $stable(pwr_save_o); endproperty
    a_nop: assert property (p_nop)
        else $error("no-op changed state");
    property p_psave; opw && wdata_i[7:1] == lpdcd_pkg::OP_PWR_SAVE[7:1]
        |=> pwr_save_o == $past(wdata_i[0]); endproperty
    a_psave: assert property (p_psave)
        else $error("power save wrong");
    property p_dis; opw && wdata_i[7:1] == lpdcd_pkg::OP_DISCHARGE[7:1]
        |=> ##1 discharge_o == $past(wdata_i[0], 2); endproperty
    a_dis: assert property (p_dis)
        else $error("discharge wrong");
    property p_stop; pwr_save_o |=> !osc_run_o && drivers_gnd_o; endproperty
    a_stop: assert property (p_stop)
        else $error("stages not stopped");
    property p_blank; $rose(pwr_save_o) |=> !display_blank_out_o; endproperty
    a_blank: assert property (p_blank)
        else $error("blank not low");
    property p_restore; $fell(pwr_save_o) |=> osc_run_o &&
        display_blank_out_o && !drivers_gnd_o; endproperty
    a_restore: assert property (p_restore)
        else $error("no restore");
    property p_ovl; nline_inv_on_i && !settings_o.inversion_overlap_off
        |=> frame_overlap_o; endproperty
    a_ovl: assert property (p_ovl)
        else $error("overlap missing");
    property p_cons; 1'b1 |=> consecutive_select_drive_o ==
        $past(settings_o.consecutive_select_drive); endproperty
    a_cons: assert property (p_cons)
        else $error("consecutive wrong");

    c_save: cover property ($rose(pwr_save_o));
    c_stat: cover property (opw && wdata_i == lpdcd_pkg::OP_STATUS);
    c_ovl:  cover property (frame_overlap_o);
endmodule : lpdcd_asserts

bind lpdcd_decoder lpdcd_asserts u_chk (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .cmd_data_select_i(cmd_data_select_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .nline_inv_on_i(nline_inv_on_i),
    .settings_o(settings_o), .pwr_save_o(pwr_save_o), .osc_run_o(osc_run_o),
    .drivers_gnd_o(drivers_gnd_o), .display_blank_out_o(display_blank_out_o),
    .discharge_o(discharge_o), .frame_overlap_o(frame_overlap_o),
    .consecutive_select_drive_o(consecutive_select_drive_o));

// ===== sim/lpdcd_decoder_tb.sv
// Testbench: drive and power command decoder
`timescale 1ns/1ps
module lpdcd_decoder_tb;
    logic                     core_clk_i, rst_n_i, sel, wr, rd, nline;
    logic [7:0]               wdata, rdata, rv;
    lpdcd_pkg::lpd_settings_t set;
    logic                     psave, osc, sup, gnd, blank, dis, ovl, cons;
    int                       n_errors = 0;
    int                       n_compared = 0;
    // Opcode, parameter, expected field; drive low bits 011
    logic [23:0] rows [12] = '{24'hA20000, 24'hA20101, 24'hA20202,
        24'h81FF7F, 24'h814545, 24'h4E0707, 24'h4E0505, 24'hE71B03,
        24'hE70300, 24'hE70B01, 24'h290001, 24'h280000};

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    lpdcd_host_model host (.core_clk_i(core_clk_i), .rdata_i(rdata),
        .cmd_data_select_o(sel), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    lpdcd_decoder dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .cmd_data_select_i(sel), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
        .rdata_o(rdata), .nline_inv_on_i(nline), .settings_o(set),
        .pwr_save_o(psave), .osc_run_o(osc), .supply_run_o(sup),
        .drivers_gnd_o(gnd), .display_blank_out_o(blank),
        .discharge_o(dis), .frame_overlap_o(ovl),
        .consecutive_select_drive_o(cons));

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    // Two idle cycles let settings and then stage outputs land
    task automatic cmd(input logic [7:0] op, p, input logic two);
        host.put(1'b0, op);
        if (two) host.put(1'b1, p);
        host.idle();
        host.idle();
        #1;
    endtask : cmd

    function automatic logic [15:0] field(input logic [7:0] op);
        case (op)
            8'hA2:   return 16'(set.bias_sel);
            8'h81:   return 16'(set.volume);
            8'h4E:   return 16'(set.temp_slope_sel);
            8'hE7:   return 16'({set.inversion_overlap_off,
                                 set.consecutive_select_drive});
            default: return 16'(set.sensor_en);
        endcase
    endfunction : field

    initial begin
        #20000;
        n_errors++;
        finish_test();
    end

    initial begin
        nline   = 1'b0;
        rst_n_i = 1'b0;
        repeat (16) @(posedge core_clk_i);
        chk("discharge_in_reset", 16'(dis), 16'h0001);
        chk("settings_reset", 16'(set), 16'h0001);
        chk("temp_reset", 16'(set.temp_slope_sel), 16'h0000);
        chk("sensor_reset", 16'(set.sensor_en), 16'h0000);
        chk("drive_reset", 16'(set[1:0]), 16'h0001);
        rst_n_i <= 1'b1;
        cmd(lpdcd_pkg::OP_NOP, 8'h00, 1'b0);
        chk("discharge_after_reset", 16'(dis), 16'h0000);
        foreach (rows[i]) begin
            cmd(rows[i][23:16], rows[i][15:8],
                rows[i][23:16] inside {8'hA2, 8'h81, 8'h4E, 8'hE7});
            chk("row_field",
                field(rows[i][23:16]),
                16'(rows[i][7:0]));
        end
        cmd(lpdcd_pkg::OP_BIAS, 8'h02, 1'b1);
        cmd(lpdcd_pkg::OP_BIAS, 8'h03, 1'b1);
        chk("bias_refused", 16'(set.bias_sel), 16'h0002);
        host.put(1'b0, lpdcd_pkg::OP_VOLUME);
        cmd(lpdcd_pkg::OP_NOP, 8'h22, 1'b1);
        chk("volume_after_nop", 16'(set.volume),
            16'h0045);
        host.put(1'b0, lpdcd_pkg::OP_STATUS);
        host.get(rv);
        chk("status_read", 16'(rv[2:0]), 16'h0005);
        cmd(8'hEB, 8'h00, 1'b0);
        chk("discharge_on", 16'(dis), 16'h0001);
        cmd(lpdcd_pkg::OP_DISCHARGE, 8'h00, 1'b0);
        chk("discharge_off", 16'(dis), 16'h0000);
        @(posedge core_clk_i) nline <= 1'b1;
        cmd(lpdcd_pkg::OP_NOP, 8'h00, 1'b0);
        chk("overlap_on", 16'(ovl), 16'h0001);
        // Bit 3 cleared so the stage output must leave its reset level
        cmd(lpdcd_pkg::OP_DRIVE, 8'h13, 1'b1);
        chk("overlap_off", 16'(ovl), 16'h0000);
        chk("consecutive", 16'(cons), 16'h0000);
        cmd(8'hA9, 8'h00, 1'b0);
        chk("save_stages", 16'({psave, osc, sup, gnd, blank}),
            16'h0012);
        chk("save_keeps_volume", 16'(set.volume), 16'h0045);
        cmd(lpdcd_pkg::OP_PWR_SAVE, 8'h00, 1'b0);
        chk("save_exit", 16'({psave, osc, sup, gnd, blank}),
            16'h000D);
        @(posedge core_clk_i) rst_n_i <= 1'b0;
        host.idle();
        #1;
        chk("settings_rereset", 16'(set), 16'h0001);
        chk("discharge_rereset", 16'(dis), 16'h0001);
        finish_test();
    end
endmodule : lpdcd_decoder_tb
